// >>> inc/outcond_pkg.sv
// constants for the per-channel output conditioning block
// assumes a 12-bit converter input and a 16-bit word register port
package outcond_pkg;
  localparam int SAMPLE_W      = 12;
  localparam int CENTRE_W      = 9;
  localparam int OUTER_W       = 8;
  localparam int COEF_FRAC     = 7;
  localparam int ATTEN_W       = 10;
  localparam int ATTEN_SHIFT   = 12;
  localparam int LANES         = 16;
  localparam int FLASH_LEN     = 16;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;
  localparam int ZONES         = 4;
  localparam int ZONE_W        = 2;
  localparam int BOOST_FRAC    = 4;
  // boost of 1.1 in unsigned 1.4 would be coarse, so use 1.10 form: 1126/1024
  localparam logic [10:0] BOOST_MULT = 11'h466;
  localparam int BOOST_SHIFT   = 10;

  // register offsets (word addresses)
  localparam logic [ADDR_W-1:0] REG_A_CENTRE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_A_OUTER  = 8'h01;
  localparam logic [ADDR_W-1:0] REG_B_CENTRE = 8'h02;
  localparam logic [ADDR_W-1:0] REG_B_OUTER  = 8'h03;
  localparam logic [ADDR_W-1:0] REG_A_ATTEN  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_B_ATTEN  = 8'h05;
  localparam logic [ADDR_W-1:0] REG_A_ZONE0  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_B_ZONE0  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_UPSAMPLE = 8'h11;
  localparam logic [ADDR_W-1:0] REG_A_LANES  = 8'h12;
  localparam logic [ADDR_W-1:0] REG_B_LANES  = 8'h13;
  localparam logic [ADDR_W-1:0] REG_CONST    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h15;

  // control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_W    = 2;
  localparam int CTRL_FLASH2    = 2;
  localparam int CTRL_BEAM_EN   = 3;
  localparam int CTRL_BOOST     = 4;
  localparam int CTRL_PHASE_SAW = 5;
  localparam int CTRL_ZONE_LSB  = 6;

  // reset values, sample extremes and last count of the wide flash
  localparam logic [CENTRE_W-1:0] CENTRE_RST = 9'h080;
  localparam logic [OUTER_W-1:0]  OUTER_RST  = 8'h00;
  localparam logic [LANES-1:0]    LANES_RST  = 16'hffff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 12'h7ff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 12'h800;
  localparam logic [3:0]          FLASH_WIDE_LAST = 4'h1;

  typedef enum logic [1:0] {
    TM_NORMAL = 2'h0,
    TM_RAMP   = 2'h1,
    TM_FLASH  = 2'h2,
    TM_CONST  = 2'h3
  } test_mode_t;
endpackage : outcond_pkg

// >>> design/outcond_channel.sv
// one channel: attenuation, boost, 3-tap anti-sinc, saturation
// assumes signed two's complement samples arriving one per clock
`timescale 1ns/10ps
module outcond_channel
  import outcond_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       run_in,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic        [ATTEN_W-1:0]  atten_in,
  input  wire logic                       boost_in,
  input  wire logic        [CENTRE_W-1:0] centre_in,
  input  wire logic        [OUTER_W-1:0]  outer_in,
  output logic signed      [SAMPLE_W-1:0] filt_out
);
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [31:0] v);
    if (v > $signed({20'h0, SAMPLE_MAX}))
      sat = SAMPLE_MAX;
    else if (v < -$signed({20'h0, SAMPLE_MAX}) - 32'sd1)
      sat = SAMPLE_MIN;
    else
      sat = v[SAMPLE_W-1:0];
  endfunction : sat

  logic signed [SAMPLE_W-1:0] gained_r;
  logic signed [SAMPLE_W-1:0] d1_r;
  logic signed [SAMPLE_W-1:0] d2_r;
  logic signed [31:0]         g_mul;
  logic signed [31:0]         g_boost;
  logic signed [31:0]         acc;

  always_comb begin
    // gain = 1 - atten*2^-12 : x*(4096-atten)>>12, never above unity
    // factors forced signed: an unsigned factor would turn negative samples into large positives
    g_mul   = (32'(sample_in) * $signed((32'sd1 <<< ATTEN_SHIFT) - 32'(atten_in))) >>> ATTEN_SHIFT;
    g_boost = boost_in ? ((g_mul * $signed(32'(BOOST_MULT))) >>> BOOST_SHIFT) : g_mul;
  end

  // signed coefficients: centre 2.7, outer 1.7
  always_comb begin
    acc = 32'($signed(outer_in)) * 32'(gained_r) + 32'($signed(centre_in)) * 32'(d1_r)
        + 32'($signed(outer_in)) * 32'(d2_r);
    acc = (acc + (32'sd1 <<< (COEF_FRAC - 1))) >>> COEF_FRAC;
  end

  // sync holds the pipeline in reset, so the taps restart from zero
  always_ff @(posedge ref_clk_in) begin
    if (!run_in) begin
      gained_r <= '0;
      d1_r     <= '0;
      d2_r     <= '0;
      filt_out <= '0;
    end else begin
      gained_r <= sat(g_boost);
      d1_r     <= gained_r;
      d2_r     <= d1_r;
      filt_out <= sat(acc);
    end
  end
endmodule : outcond_channel

// >>> design/outcond_top.sv
// output conditioning for two converter cores: gain, anti-sinc, lane power, test patterns
// assumes samples synchronous to ref_clk_in and a one-cycle-latency register port
`timescale 1ns/10ps
// How it works
// - each channel has a symmetric three-tap filter with two programmable coefficients.
// - output is outer*x[n] plus centre*x[n-1] plus outer*x[n-2].
// - centre uses coefficient one, outer coefficient two; each channel has its own.
// - centre coefficient is nine bits with seven fractional bits.
// - outer coefficient is eight bits with seven fractional bits.
// - samples pass a gain stage before the filter.
// - gain setting is a ten-bit value written by software.
// - without beam steering, gain is one minus channel attenuation times 2^-12.
// - with beam steering, attenuation comes from one of four zone registers.
// - boost bit multiplies the overall gain by 1.1.
// - lane mask bit n powers serial lane n of that core.
// - both cores share one upsampling ratio select register.
// - ramp mode outputs an incrementing 12-bit ramp cleared by sync.
// - optionally the oscillator phase is routed out as a sawtooth.
// - flash mode loops one maximum then fifteen minimum samples.
// - wide flash gives two maximum then fourteen minimum samples.
// - constant mode outputs a software-programmed value.
// - while sync is high the sample path is held in reset.
module outcond_top
  import outcond_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       sync_in,
  input  wire logic        [ADDR_W-1:0]   reg_addr_in,
  input  wire logic        [DATA_W-1:0]   reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic             [DATA_W-1:0]   reg_rdata_out,
  input  wire logic signed [SAMPLE_W-1:0] chan_a_sample_in,
  input  wire logic signed [SAMPLE_W-1:0] chan_b_sample_in,
  input  wire logic        [SAMPLE_W-1:0] chan_a_phase_in,
  input  wire logic        [SAMPLE_W-1:0] chan_b_phase_in,
  output logic             [SAMPLE_W-1:0] chan_a_dac_out,
  output logic             [SAMPLE_W-1:0] chan_b_dac_out,
  output logic             [LANES-1:0]    chan_a_lane_power_mask_out,
  output logic             [LANES-1:0]    chan_b_lane_power_mask_out,
  output logic             [DATA_W-1:0]   upsample_ratio_select_out
);
  logic [CENTRE_W-1:0] chan_a_centre_tap_coeff_r;
  logic [CENTRE_W-1:0] chan_b_centre_tap_coeff_r;
  logic [OUTER_W-1:0]  chan_a_outer_tap_coeff_r;
  logic [OUTER_W-1:0]  chan_b_outer_tap_coeff_r;
  logic [ATTEN_W-1:0]  chan_a_attenuation_r;
  logic [ATTEN_W-1:0]  chan_b_attenuation_r;
  logic [ATTEN_W-1:0]  chan_a_zone_attenuation_r [ZONES];
  logic [ATTEN_W-1:0]  chan_b_zone_attenuation_r [ZONES];
  logic [DATA_W-1:0]   ctrl_r;
  logic [DATA_W-1:0]   upsample_ratio_select_r;
  logic [LANES-1:0]    chan_a_lane_power_mask_r;
  logic [LANES-1:0]    chan_b_lane_power_mask_r;
  logic [SAMPLE_W-1:0] const_r;
  logic [SAMPLE_W-1:0] ramp_r;
  logic [3:0]          flash_cnt_r;
  logic [DATA_W-1:0]   rdata_nxt;

  logic signed [SAMPLE_W-1:0] chan_a_filt;
  logic signed [SAMPLE_W-1:0] chan_b_filt;
  logic [ATTEN_W-1:0]  chan_a_gain_sel;
  logic [ATTEN_W-1:0]  chan_b_gain_sel;
  logic [ZONE_W-1:0]   zone;
  logic                run;
  logic                core_boost_bit;
  logic                beam_en;
  logic                flash_wide;
  logic                phase_saw;
  test_mode_t          mode;
  logic [SAMPLE_W-1:0] flash_val;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    hit = (a == base);
  endfunction : hit

  assign run            = ~sync_in;
  assign mode           = test_mode_t'(ctrl_r[CTRL_MODE_LSB +: CTRL_MODE_W]);
  assign flash_wide     = ctrl_r[CTRL_FLASH2];
  assign beam_en        = ctrl_r[CTRL_BEAM_EN];
  assign core_boost_bit = ctrl_r[CTRL_BOOST];
  assign phase_saw      = ctrl_r[CTRL_PHASE_SAW];
  assign zone           = ctrl_r[CTRL_ZONE_LSB +: ZONE_W];

  // coefficient and attenuation storage
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      chan_a_centre_tap_coeff_r <= CENTRE_RST;
      chan_b_centre_tap_coeff_r <= CENTRE_RST;
      chan_a_outer_tap_coeff_r  <= OUTER_RST;
      chan_b_outer_tap_coeff_r  <= OUTER_RST;
      chan_a_attenuation_r      <= '0;
      chan_b_attenuation_r      <= '0;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, REG_A_CENTRE)) chan_a_centre_tap_coeff_r <= reg_wdata_in[CENTRE_W-1:0];
      if (hit(reg_addr_in, REG_B_CENTRE)) chan_b_centre_tap_coeff_r <= reg_wdata_in[CENTRE_W-1:0];
      if (hit(reg_addr_in, REG_A_OUTER))  chan_a_outer_tap_coeff_r  <= reg_wdata_in[OUTER_W-1:0];
      if (hit(reg_addr_in, REG_B_OUTER))  chan_b_outer_tap_coeff_r  <= reg_wdata_in[OUTER_W-1:0];
      if (hit(reg_addr_in, REG_A_ATTEN))  chan_a_attenuation_r      <= reg_wdata_in[ATTEN_W-1:0];
      if (hit(reg_addr_in, REG_B_ATTEN))  chan_b_attenuation_r      <= reg_wdata_in[ATTEN_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < ZONES; i++) begin
      if (sys_rst_in) begin
        chan_a_zone_attenuation_r[i] <= '0;
        chan_b_zone_attenuation_r[i] <= '0;
      end else if (reg_wr_in) begin
        if (hit(reg_addr_in, REG_A_ZONE0 + ADDR_W'(i)))
          chan_a_zone_attenuation_r[i] <= reg_wdata_in[ATTEN_W-1:0];
        if (hit(reg_addr_in, REG_B_ZONE0 + ADDR_W'(i)))
          chan_b_zone_attenuation_r[i] <= reg_wdata_in[ATTEN_W-1:0];
      end
    end
  end

  // control, lane power and constant value
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl_r                   <= '0;
      upsample_ratio_select_r  <= '0;
      chan_a_lane_power_mask_r <= LANES_RST;
      chan_b_lane_power_mask_r <= LANES_RST;
      const_r                  <= '0;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, REG_CTRL))     ctrl_r                   <= reg_wdata_in;
      if (hit(reg_addr_in, REG_UPSAMPLE)) upsample_ratio_select_r  <= reg_wdata_in;
      if (hit(reg_addr_in, REG_A_LANES))  chan_a_lane_power_mask_r <= reg_wdata_in;
      if (hit(reg_addr_in, REG_B_LANES))  chan_b_lane_power_mask_r <= reg_wdata_in;
      if (hit(reg_addr_in, REG_CONST))    const_r                  <= reg_wdata_in[SAMPLE_W-1:0];
    end
  end

  // each lane mask bit drives its lane's power switch directly
  assign chan_a_lane_power_mask_out = chan_a_lane_power_mask_r;
  assign chan_b_lane_power_mask_out = chan_b_lane_power_mask_r;
  assign upsample_ratio_select_out  = upsample_ratio_select_r;

  // read port: data one cycle after the strobe, unmapped reads as zero
  always_comb begin
    rdata_nxt = '0;
    case (reg_addr_in)
      REG_A_CENTRE: rdata_nxt = DATA_W'(chan_a_centre_tap_coeff_r);
      REG_A_OUTER:  rdata_nxt = DATA_W'(chan_a_outer_tap_coeff_r);
      REG_B_CENTRE: rdata_nxt = DATA_W'(chan_b_centre_tap_coeff_r);
      REG_B_OUTER:  rdata_nxt = DATA_W'(chan_b_outer_tap_coeff_r);
      REG_A_ATTEN:  rdata_nxt = DATA_W'(chan_a_attenuation_r);
      REG_B_ATTEN:  rdata_nxt = DATA_W'(chan_b_attenuation_r);
      REG_CTRL:     rdata_nxt = ctrl_r;
      REG_UPSAMPLE: rdata_nxt = upsample_ratio_select_r;
      REG_A_LANES:  rdata_nxt = chan_a_lane_power_mask_r;
      REG_B_LANES:  rdata_nxt = chan_b_lane_power_mask_r;
      REG_CONST:    rdata_nxt = DATA_W'(const_r);
      REG_STATUS:   rdata_nxt = {flash_cnt_r, ramp_r};
      default: begin
        for (int i = 0; i < ZONES; i++) begin
          if (reg_addr_in == REG_A_ZONE0 + ADDR_W'(i)) rdata_nxt = DATA_W'(chan_a_zone_attenuation_r[i]);
          if (reg_addr_in == REG_B_ZONE0 + ADDR_W'(i)) rdata_nxt = DATA_W'(chan_b_zone_attenuation_r[i]);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_nxt;
    else
      reg_rdata_out <= '0;
  end

  // zone registers replace the per-channel attenuation while beam steering is on
  assign chan_a_gain_sel = beam_en ? chan_a_zone_attenuation_r[zone] : chan_a_attenuation_r;
  assign chan_b_gain_sel = beam_en ? chan_b_zone_attenuation_r[zone] : chan_b_attenuation_r;

  // gain, boost and filter per channel; order is inside the channel pipeline
  outcond_channel u_chan_a (
    .ref_clk_in (ref_clk_in),
    .run_in     (run & ~sys_rst_in),
    .sample_in  (chan_a_sample_in),
    .atten_in   (chan_a_gain_sel),
    .boost_in   (core_boost_bit),
    .centre_in  (chan_a_centre_tap_coeff_r),
    .outer_in   (chan_a_outer_tap_coeff_r),
    .filt_out   (chan_a_filt)
  );

  outcond_channel u_chan_b (
    .ref_clk_in (ref_clk_in),
    .run_in     (run & ~sys_rst_in),
    .sample_in  (chan_b_sample_in),
    .atten_in   (chan_b_gain_sel),
    .boost_in   (core_boost_bit),
    .centre_in  (chan_b_centre_tap_coeff_r),
    .outer_in   (chan_b_outer_tap_coeff_r),
    .filt_out   (chan_b_filt)
  );

  // ramp restarts at zero whenever sync is seen
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || sync_in)
      ramp_r <= '0;
    else
      ramp_r <= ramp_r + SAMPLE_W'(1);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || sync_in)
      flash_cnt_r <= '0;
    else
      flash_cnt_r <= flash_cnt_r + 4'h1;
  end

  // offset-binary extremes are fed as signed max and min
  assign flash_val = (flash_cnt_r == '0 || (flash_wide && flash_cnt_r == FLASH_WIDE_LAST))
                   ? SAMPLE_MAX : SAMPLE_MIN;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      chan_a_dac_out <= '0;
      chan_b_dac_out <= '0;
    end else begin
      case (mode)
        TM_NORMAL: begin
          chan_a_dac_out <= chan_a_filt;
          chan_b_dac_out <= chan_b_filt;
        end
        TM_RAMP: begin
          chan_a_dac_out <= phase_saw ? chan_a_phase_in : ramp_r;
          chan_b_dac_out <= phase_saw ? chan_b_phase_in : ramp_r;
        end
        TM_FLASH: begin
          chan_a_dac_out <= flash_val;
          chan_b_dac_out <= flash_val;
        end
        TM_CONST: begin
          chan_a_dac_out <= const_r;
          chan_b_dac_out <= const_r;
        end
        default: begin
          chan_a_dac_out <= chan_a_filt;
          chan_b_dac_out <= chan_b_filt;
        end
      endcase
    end
  end

  // the ramp_step_a and normal_out_a antecedents sample reset too, so the edge that releases it never starts a false attempt
  ramp_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_in |=> ramp_r == '0) else $error("ramp not cleared by sync");
  ramp_step_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !sync_in && !sys_rst_in |=> ramp_r == $past(ramp_r) + SAMPLE_W'(1)) else $error("ramp did not step");
  flash_loop_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in || sync_in)
    flash_cnt_r == 4'hf |=> flash_cnt_r == 4'h0) else $error("flash period not 16");
  flash_one_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !flash_wide && flash_cnt_r == 4'h1 |-> flash_val == SAMPLE_MIN) else $error("flash too wide");
  flash_two_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    flash_wide && flash_cnt_r == 4'h1 |-> flash_val == SAMPLE_MAX) else $error("wide flash short");
  const_out_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == TM_CONST |=> chan_a_dac_out == $past(const_r)) else $error("constant not output");
  gain_sel_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !beam_en |-> chan_a_gain_sel == chan_a_attenuation_r) else $error("wrong attenuation source");
  zone_sel_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    beam_en |-> chan_b_gain_sel == chan_b_zone_attenuation_r[zone]) else $error("wrong zone source");
  lane_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == REG_A_LANES |=> chan_a_lane_power_mask_out == $past(reg_wdata_in))
    else $error("lane mask not applied");
  sync_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_in ##1 sync_in |-> chan_a_filt == '0) else $error("sample path not held");
  hold_b_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_in ##1 sync_in |-> chan_b_filt == '0) else $error("channel b path not held");
  flash_sync_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sync_in |=> flash_cnt_r == '0) else $error("flash count not held by sync");
  // each pattern source reaches the pins one cycle after it is sampled
  rst_mode_a: assert property (@(posedge ref_clk_in)
    sys_rst_in |=> mode == TM_NORMAL && chan_a_dac_out == '0) else $error("reset left a test pattern");
  normal_out_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !sys_rst_in && mode == TM_NORMAL |=> chan_a_dac_out == $past(chan_a_filt)) else $error("filter not output");
  ramp_out_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == TM_RAMP && !phase_saw |=> chan_a_dac_out == $past(ramp_r)) else $error("ramp not output");
  saw_out_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == TM_RAMP && phase_saw |=> chan_b_dac_out == $past(chan_b_phase_in)) else $error("phase not output");
  flash_out_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == TM_FLASH |=> chan_b_dac_out == $past(flash_val)) else $error("flash not output");
  const_b_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == TM_CONST |=> chan_b_dac_out == $past(const_r)) else $error("constant not on channel b");
  lane_b_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == REG_B_LANES |=> chan_b_lane_power_mask_out == $past(reg_wdata_in))
    else $error("channel b lane mask not applied");
  atten_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == REG_A_ATTEN |=> chan_a_attenuation_r == $past(reg_wdata_in[ATTEN_W-1:0]))
    else $error("attenuation not stored");
  centre_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == REG_B_CENTRE |=> chan_b_centre_tap_coeff_r == $past(reg_wdata_in[CENTRE_W-1:0]))
    else $error("centre coefficient not stored");
  ratio_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == REG_UPSAMPLE |=> upsample_ratio_select_out == $past(reg_wdata_in))
    else $error("upsampling ratio not applied");
endmodule : outcond_top

// >>> bench/sample_src.sv
// far-side sample transmitter: sends one sample per clock on each channel
// assumes the bench sets the level it wants sent; the value is launched after a rising edge
`timescale 1ns/10ps
module sample_src
  import outcond_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic signed [SAMPLE_W-1:0] a_level_in,
  input  wire logic signed [SAMPLE_W-1:0] b_level_in,
  output logic signed      [SAMPLE_W-1:0] chan_a_sample_out,
  output logic signed      [SAMPLE_W-1:0] chan_b_sample_out
);
  // registered so the samples never change in the edge that takes them
  always_ff @(posedge ref_clk_in) begin
    chan_a_sample_out <= a_level_in;
    chan_b_sample_out <= b_level_in;
  end
endmodule : sample_src

// >>> bench/tb.sv
// self-checking bench for the output conditioning block
// assumes one-cycle read latency and 100 MHz clock; samples come from sample_src
`timescale 1ns/10ps
module tb;
  import outcond_pkg::*;
  logic                       ref_clk_in   = 1'b0;
  logic                       sys_rst_in   = 1'b1;
  logic                       sync_in      = 1'b0;
  logic        [ADDR_W-1:0]   reg_addr_in  = 8'h00;
  logic        [DATA_W-1:0]   reg_wdata_in = 16'h0000;
  logic                       reg_wr_in    = 1'b0;
  logic                       reg_rd_in    = 1'b0;
  logic        [DATA_W-1:0]   rdata;
  logic signed [SAMPLE_W-1:0] a_lvl = 12'h000, b_lvl = 12'h000, a_smp, b_smp;
  logic        [SAMPLE_W-1:0] a_ph = 12'h000, b_ph = 12'h000, a_dac, b_dac;
  logic        [LANES-1:0]    a_mask, b_mask;
  logic        [DATA_W-1:0]   ratio, rv;
  logic        [SAMPLE_W-1:0] v [32];
  int                         bad_count = 0, cmp_count = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  sample_src sample_src_i (.ref_clk_in(ref_clk_in), .a_level_in(a_lvl), .b_level_in(b_lvl),
    .chan_a_sample_out(a_smp), .chan_b_sample_out(b_smp));
  outcond_top outcond_top_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .sync_in(sync_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .chan_a_sample_in(a_smp),
    .chan_b_sample_in(b_smp), .chan_a_phase_in(a_ph), .chan_b_phase_in(b_ph),
    .chan_a_dac_out(a_dac), .chan_b_dac_out(b_dac), .chan_a_lane_power_mask_out(a_mask),
    .chan_b_lane_power_mask_out(b_mask), .upsample_ratio_select_out(ratio));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    cmp_count++;
    if (act !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic steady(input logic [11:0] ea, input logic [11:0] eb);
    repeat (10) @(posedge ref_clk_in);
    #1 chk({4'h0, a_dac}, {4'h0, ea});
    chk({4'h0, b_dac}, {4'h0, eb});
  endtask : steady
  // bounded wait: a value never reached is reported by the compares
  task automatic wait_eq(input logic [11:0] ea, input logic [11:0] eb);
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk_in);
      #1 if (a_dac === ea && b_dac === eb) break;
    end
    chk({4'h0, a_dac}, {4'h0, ea});
    chk({4'h0, b_dac}, {4'h0, eb});
  endtask : wait_eq
  task automatic sync_pulse();
    @(posedge ref_clk_in) sync_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sync_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    for (int i = 0; i < 32; i++) begin
      #1 v[i] = a_dac;
      @(posedge ref_clk_in);
    end
  endtask : sync_pulse
  task automatic flash_chk(input int wide);
    int nmax, nmin, npair, nrep;
    nmax = 0; nmin = 0; npair = 0; nrep = 0;
    for (int i = 0; i < 16; i++) begin
      if (v[i] === SAMPLE_MAX) nmax++;
      if (v[i] === SAMPLE_MIN) nmin++;
      if (v[i] === SAMPLE_MAX && v[i+1] === SAMPLE_MAX) npair++;
      if (v[i] !== v[i+16]) nrep++;
    end
    chk(16'(nmax), 16'(1 + wide));
    chk(16'(nmin), 16'(15 - wide));
    chk(16'(npair), 16'(wide));
    chk(16'(nrep), 16'h0000);
  endtask : flash_chk
  logic [15:0] ratios [4] = '{16'h0005, 16'h000a, 16'h000f, 16'h0000};
  logic [15:0] masks  [4] = '{16'h01fe, 16'h001e, 16'h0006, 16'hffff};
  initial begin
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    #1 chk(a_mask, 16'hffff);
    chk(ratio, 16'h0000);
    rd(REG_A_CENTRE, rv); chk(rv, 16'h0080);
    rd(REG_B_OUTER, rv); chk(rv, 16'h0000);
    rd(REG_CTRL, rv); chk(rv, 16'h0000);
    rd(8'h30, rv); chk(rv, 16'h0000);
    // controller sequences for each upsampling ratio, written before the sync pulse
    for (int k = 0; k < 4; k++) begin
      wr(REG_UPSAMPLE, ratios[k]);
      wr(REG_A_LANES, masks[k]);
      wr(REG_B_LANES, masks[k]);
      rd(REG_B_LANES, rv); chk(rv, masks[k]);
      chk(ratio, ratios[k]);
      chk(a_mask, masks[k]);
      chk(b_mask, masks[k]);
    end
    wr(REG_A_LANES, 16'h001e);
    wr(REG_B_LANES, 16'h0006);
    @(posedge ref_clk_in) #1 chk(a_mask, 16'h001e);
    chk(b_mask, 16'h0006);
    a_lvl <= 12'h400; b_lvl <= 12'h400;
    steady(12'h400, 12'h400);
    wr(REG_A_ATTEN, 16'h0100);
    steady(12'h3c0, 12'h400);
    wr(REG_A_ATTEN, 16'h0000);
    wr(REG_CTRL, 16'h0010);
    steady(12'h466, 12'h466);
    wr(REG_A_ATTEN, 16'h01ff);
    steady(12'h3d9, 12'h466);
    wr(REG_A_ATTEN, 16'h0000);
    wr(REG_A_ZONE0 + 8'h02, 16'h0100);
    wr(REG_B_ZONE0 + 8'h02, 16'h0200);
    wr(REG_CTRL, 16'h0088);
    steady(12'h3c0, 12'h380);
    wr(REG_CTRL, 16'h0000);
    // step response shows the tap order: outer, outer+centre, full sum
    wr(REG_A_OUTER, 16'h0040);
    a_lvl <= 12'h000; b_lvl <= 12'h000;
    steady(12'h000, 12'h000);
    a_lvl <= 12'h100;
    for (int i = 0; i < 12 && a_dac === 12'h000; i++) @(posedge ref_clk_in) #1;
    chk({4'h0, a_dac}, 16'h0080);
    @(posedge ref_clk_in) #1 chk({4'h0, a_dac}, 16'h0180);
    @(posedge ref_clk_in) #1 chk({4'h0, a_dac}, 16'h0200);
    wr(REG_B_CENTRE, 16'h00ff);
    a_lvl <= 12'h7ff; b_lvl <= 12'h7ff;
    steady(12'h7ff, 12'h7ff);
    b_lvl <= 12'h800;
    steady(12'h7ff, 12'h800);
    wr(REG_CONST, 16'h05a5);
    wr(REG_CTRL, 16'h0003);
    wait_eq(12'h5a5, 12'h5a5);
    wr(REG_CTRL, 16'h0002);
    sync_pulse();
    flash_chk(0);
    wr(REG_CTRL, 16'h0006);
    sync_pulse();
    flash_chk(1);
    wr(REG_CTRL, 16'h0001);
    sync_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rd(REG_STATUS, rv); chk({4'h0, rv[11:0]}, 16'h0000);
    sync_pulse();
    chk({4'h0, v[0]}, 16'h0007);
    chk({4'h0, v[1]}, {4'h0, v[0] + 12'h001});
    chk({4'h0, v[31]}, {4'h0, v[0] + 12'h01f});
    a_ph <= 12'h123; b_ph <= 12'h456;
    wr(REG_CTRL, 16'h0021);
    wait_eq(12'h123, 12'h456);
    give_verdict();
  end
  initial begin
    #900000;
    bad_count++;
    give_verdict();
  end
endmodule : tb
